/* core/tfr_core.v */
/*
 * Holds the temperature limit registers, the delay unit register and the
 * under-temperature fault response machine of the converter manager.
 * Assumes the command port, the temperature sample and the control inputs
 * all come from logic on clk; the temperature and limits share one signed
 * 16-bit scale, so they compare directly.
 */
`include "tfr_consts.vh"

module tfr_core (
    clk,
    nrst,
    cmd_valid,
    cmd_write,
    cmd_code,
    cmd_wdata,
    temperature,
    status_clear,
    clear_faults,
    output_cmd_on,
    bias_ok,
    cmd_rdata_q,
    cmd_ack_q,
    output_en_q,
    ut_fault_flag_q,
    ot_warn_q,
    ut_warn_q,
    latched_off_q
);
    input wire clk; // 50 MHz system clock
    input wire nrst; // asynchronous reset, active low
    input wire cmd_valid; // one-cycle command strobe
    input wire cmd_write; // 1 write, 0 read
    input wire [7:0] cmd_code; // command code
    input wire [15:0] cmd_wdata; // write data, low bits used for narrow registers
    input wire [15:0] temperature; // signed measured temperature
    input wire status_clear; // pulse: clear the fault status bit
    input wire clear_faults; // pulse: clear all faults
    input wire output_cmd_on; // level: output commanded on
    input wire bias_ok; // level: bias power present
    output reg [15:0] cmd_rdata_q; // read data
    output reg cmd_ack_q; // answer strobe
    output reg output_en_q; // converter output enable
    output reg ut_fault_flag_q; // sticky fault status bit
    output reg ot_warn_q; // over-temperature warning
    output reg ut_warn_q; // under-temperature warning
    output reg latched_off_q; // off until fault cleared

    // ============================================================
    // states
    localparam ST_RUN = 2'h0; // output follows command
    localparam ST_DELAY = 2'h1; // still running, fault delay counting
    localparam ST_WAIT = 2'h2; // output off, waiting for next attempt
    localparam ST_LATCH = 2'h3; // off until cleared

    reg [15:0] ot_warn_lim_q; // over-temperature warning threshold
    reg [15:0] ut_warn_lim_q; // under-temperature warning threshold
    reg [15:0] ut_fault_lim_q; // under-temperature fault threshold
    reg [7:0] ut_action_q; // under-temperature fault action byte
    reg [15:0] delay_unit_q; // clock cycles per delay unit
    reg [1:0] state_q;
    reg [15:0] unit_cnt_q; // cycles left in current unit
    reg [7:0] units_left_q; // units left in current delay
    reg [2:0] tries_left_q; // restart attempts remaining
    reg fault_seen_q; // fault level last cycle, for edge detect
    reg off_seen_q; // output commanded off while latched

    wire fault_raw = $signed(temperature) < $signed(ut_fault_lim_q);
    wire fault_rise = fault_raw & ~fault_seen_q;
    wire any_clear = status_clear | clear_faults;
    wire [1:0] resp = ut_action_q[`TFR_RESP_HI:`TFR_RESP_LO];
    wire [2:0] retry = ut_action_q[`TFR_RETRY_HI:`TFR_RETRY_LO];
    wire [2:0] dcode = ut_action_q[`TFR_DELAY_HI:`TFR_DELAY_LO];
    wire timer_done = (units_left_q == 8'h00);

    // two to the code, in units
    function [7:0] tfr_units;
        input [2:0] code;
        begin
            tfr_units = 8'h01 << code;
        end
    endfunction

    // register index match on the write path, one compare per register
    function tfr_hit;
        input [7:0] code;
        input [7:0] want;
        begin
            tfr_hit = (code == want);
        end
    endfunction

    // ============================================================
    // command port: writes take effect at the strobe edge
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ot_warn_lim_q <= `TFR_RST_OT_WARN;
            ut_warn_lim_q <= `TFR_RST_UT_WARN;
            ut_fault_lim_q <= `TFR_RST_UT_FAULT;
            ut_action_q <= `TFR_RST_UT_ACTION;
            delay_unit_q <= `TFR_RST_DELAY_UNIT;
            cmd_rdata_q <= 16'h0000;
            cmd_ack_q <= 1'b0;
        end else begin
            cmd_ack_q <= cmd_valid;
            if (cmd_valid && cmd_write) begin
                if (tfr_hit(cmd_code, `TFR_CMD_OT_WARN)) begin
                    ot_warn_lim_q <= cmd_wdata;
                end
                if (tfr_hit(cmd_code, `TFR_CMD_UT_WARN)) begin
                    ut_warn_lim_q <= cmd_wdata;
                end
                if (tfr_hit(cmd_code, `TFR_CMD_UT_FAULT)) begin
                    ut_fault_lim_q <= cmd_wdata;
                end
                if (tfr_hit(cmd_code, `TFR_CMD_UT_ACTION)) begin
                    ut_action_q <= cmd_wdata[7:0];
                end
                if (tfr_hit(cmd_code, `TFR_CMD_DELAY_UNIT)) begin
                    delay_unit_q <= cmd_wdata;
                end
            end
            // read mux; unmapped codes answer zero
            if (cmd_valid && !cmd_write) begin
                case (cmd_code)
                    `TFR_CMD_OT_WARN: cmd_rdata_q <= ot_warn_lim_q;
                    `TFR_CMD_UT_WARN: cmd_rdata_q <= ut_warn_lim_q;
                    `TFR_CMD_UT_FAULT: cmd_rdata_q <= ut_fault_lim_q;
                    `TFR_CMD_UT_ACTION: cmd_rdata_q <= {8'h00, ut_action_q};
                    `TFR_CMD_DELAY_UNIT: cmd_rdata_q <= delay_unit_q;
                    default: cmd_rdata_q <= 16'h0000;
                endcase
            end
        end
    end

    // ============================================================
    // warnings and sticky fault status
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ot_warn_q <= 1'b0;
            ut_warn_q <= 1'b0;
            ut_fault_flag_q <= 1'b0;
            fault_seen_q <= 1'b0;
        end else begin
            ot_warn_q <= $signed(temperature) > $signed(ot_warn_lim_q);
            ut_warn_q <= $signed(temperature) < $signed(ut_warn_lim_q);
            fault_seen_q <= fault_raw;
            // a new fault in the clearing cycle wins over the clear
            if (fault_rise) begin
                ut_fault_flag_q <= 1'b1;
            end else if (any_clear || !bias_ok) begin
                ut_fault_flag_q <= 1'b0;
            end
        end
    end

    // ============================================================
    // response machine; the delay unit is stretched to at least one cycle
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_RUN;
            unit_cnt_q <= 16'h0000;
            units_left_q <= 8'h00;
            tries_left_q <= 3'h0;
            off_seen_q <= 1'b0;
        end else if (!bias_ok) begin
            // losing bias returns to run and clears the units left and the off-seen flag
            state_q <= ST_RUN;
            units_left_q <= 8'h00;
            off_seen_q <= 1'b0;
        end else begin
            // unit timer, only meaningful while a delay is running
            if (!timer_done) begin
                if (unit_cnt_q <= 16'h0001) begin
                    unit_cnt_q <= delay_unit_q;
                    units_left_q <= units_left_q - 8'h01;
                end else begin
                    unit_cnt_q <= unit_cnt_q - 16'h0001;
                end
            end
            case (state_q)
                ST_RUN: begin
                    if (fault_rise) begin
                        tries_left_q <= retry;
                        unit_cnt_q <= delay_unit_q;
                        units_left_q <= tfr_units(dcode);
                        case (resp)
                            `TFR_RESP_IGNORE: state_q <= ST_RUN;
                            `TFR_RESP_RUN_DELAY: state_q <= ST_DELAY;
                            `TFR_RESP_OFF_RETRY: state_q <= (retry == `TFR_RETRY_NONE) ? ST_LATCH : ST_WAIT;
                            default: state_q <= ST_LATCH;
                        endcase
                    end
                end
                ST_DELAY: begin
                    // keeps running; on expiry the retry setting takes over
                    if (!fault_raw) begin
                        state_q <= ST_RUN;
                    end else if (timer_done) begin
                        unit_cnt_q <= delay_unit_q;
                        units_left_q <= tfr_units(dcode);
                        state_q <= (retry == `TFR_RETRY_NONE) ? ST_LATCH : ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!output_cmd_on) begin
                        state_q <= ST_RUN;
                    end else if (timer_done) begin
                        if (!fault_raw) begin
                            state_q <= ST_RUN; // restart succeeded
                        end else if (tries_left_q == `TFR_RETRY_FOREVER) begin
                            unit_cnt_q <= delay_unit_q;
                            units_left_q <= tfr_units(dcode);
                        end else if (tries_left_q == 3'h1) begin
                            state_q <= ST_LATCH;
                        end else begin
                            tries_left_q <= tries_left_q - 3'h1;
                            unit_cnt_q <= delay_unit_q;
                            units_left_q <= tfr_units(dcode);
                        end
                    end
                end
                ST_LATCH: begin
                    if (!output_cmd_on) begin
                        off_seen_q <= 1'b1;
                    end
                    // status clear, clear command or off-then-on releases
                    if (any_clear || (off_seen_q && output_cmd_on)) begin
                        state_q <= ST_RUN;
                        off_seen_q <= 1'b0;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    // ============================================================
    // outputs registered from the current state, so they lag it by one cycle
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            output_en_q <= 1'b0;
            latched_off_q <= 1'b0;
        end else begin
            output_en_q <= output_cmd_on && bias_ok && ((state_q == ST_RUN) || (state_q == ST_DELAY));
            latched_off_q <= (state_q == ST_LATCH);
        end
    end

endmodule

/* core/tfr_consts.vh */
/*
 * Holds the command codes, field positions, reset values and response
 * encodings of the temperature fault response block.
 * Assumes it is included by its bare name from the design file only.
 */
`ifndef TFR_CONSTS_VH
`define TFR_CONSTS_VH

// ============================================================
// command codes
`define TFR_CMD_OT_WARN 8'h51
`define TFR_CMD_UT_WARN 8'h52
`define TFR_CMD_UT_FAULT 8'h53
`define TFR_CMD_UT_ACTION 8'h54
`define TFR_CMD_DELAY_UNIT 8'hD2

// ============================================================
// action byte fields
`define TFR_RESP_HI 7
`define TFR_RESP_LO 6
`define TFR_RETRY_HI 5
`define TFR_RETRY_LO 3
`define TFR_DELAY_HI 2
`define TFR_DELAY_LO 0

// ============================================================
// response and retry encodings
`define TFR_RESP_IGNORE 2'h0
`define TFR_RESP_RUN_DELAY 2'h1
`define TFR_RESP_OFF_RETRY 2'h2
`define TFR_RESP_LATCH 2'h3
`define TFR_RETRY_NONE 3'h0
`define TFR_RETRY_FOREVER 3'h7

// ============================================================
// reset values: limits parked so that nothing trips after reset
`define TFR_RST_OT_WARN 16'h7FFF
`define TFR_RST_UT_WARN 16'h8000
`define TFR_RST_UT_FAULT 16'h8000
`define TFR_RST_UT_ACTION 8'h00
`define TFR_RST_DELAY_UNIT 16'h0001

`endif

/* bench/tfr_core_monitor.sv */
/* checker on the ports of the temperature fault response core.
   assumes it is bound to tfr_core and runs on its one clock. */
module tfr_core_monitor (
    input wire clk,
    input wire nrst,
    input wire cmd_valid,
    input wire cmd_write,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    input wire [15:0] temperature,
    input wire status_clear,
    input wire clear_faults,
    input wire output_cmd_on,
    input wire bias_ok,
    input wire [15:0] cmd_rdata_q,
    input wire cmd_ack_q,
    input wire output_en_q,
    input wire ut_fault_flag_q,
    input wire ot_warn_q,
    input wire ut_warn_q,
    input wire latched_off_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // helpers and defaults
    default clocking dc @(posedge clk); endclocking
    default disable iff (!nrst);
    wire rd_req = cmd_valid && !cmd_write; // read strobe
    wire mapped = cmd_code == 8'h51 || cmd_code == 8'h52 || cmd_code == 8'h53 || cmd_code == 8'h54
        || cmd_code == 8'hD2; // known command codes
    // ====
    // assertions
    a_ack_follows: assert property (cmd_valid |=> cmd_ack_q) else $error("ack missing");
    a_ack_cause: assert property (cmd_ack_q |-> $past(cmd_valid)) else $error("ack spurious");
    a_rdata_hold: assert property (!rd_req |=> $stable(cmd_rdata_q)) else $error("rdata moved");
    a_unmapped_zero: assert property (rd_req && !mapped |=> cmd_rdata_q == 16'h0000) else $error("bad read");
    a_cmd_off: assert property (!output_cmd_on |=> !output_en_q) else $error("on while off");
    a_bias_loss: assert property (!bias_ok [*2] |=> !latched_off_q) else $error("latch kept");
    a_latch_off: assert property (latched_off_q [*2] |-> !output_en_q) else $error("on in latch");
    a_enable_cause: assert property ($rose(output_en_q) |-> $past(output_cmd_on && bias_ok))
        else $error("bad enable");
    // the status bit only drops on a clear pulse or on bias loss
    a_flag_sticky: assert property (ut_fault_flag_q && bias_ok && !status_clear && !clear_faults
        |=> ut_fault_flag_q) else $error("flag dropped");
    // ====
    // main scenarios reached
    c_latched: cover property ($rose(latched_off_q));
    c_fault: cover property ($rose(ut_fault_flag_q));
    c_ot_warn: cover property ($rose(ot_warn_q));
endmodule
bind tfr_core tfr_core_monitor tfr_core_monitor_inst (.clk, .nrst, .cmd_valid, .cmd_write, .cmd_code,
    .cmd_wdata, .temperature, .status_clear, .clear_faults, .output_cmd_on, .bias_ok, .cmd_rdata_q,
    .cmd_ack_q, .output_en_q, .ut_fault_flag_q, .ot_warn_q, .ut_warn_q, .latched_off_q);

/* bench/tfr_host.sv */
/* model of the host that issues commands to the core.
   assumes one-cycle strobes answered by ack one cycle later. */
module tfr_host (
    input wire clk,
    input wire cmd_ack_q,
    input wire [15:0] cmd_rdata_q,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // idle bus at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // one command; ack is looked at once its edge has landed
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
        output logic [15:0] r, output logic ok);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code <= c;
        cmd_wdata <= d;
        @(posedge clk);
        cmd_valid <= 1'b0; // strobe lasts one cycle only
        cmd_code <= ~c; // released code and data lines never show a stale value; cmd_write keeps its value
        cmd_wdata <= ~d;
        #1;
        ok = (cmd_ack_q === 1'b1);
        r = cmd_rdata_q;
    endtask
endmodule

/* bench/tfr_core_tb_top.sv */
/* self-checking bench of the temperature fault response core.
   assumes a 50 MHz clock and a delay unit of 2 cycles. */
module tfr_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cmd_valid, cmd_write, cmd_ack_q, output_en_q, ut_fault_flag_q, ot_warn_q, ut_warn_q, latched_off_q;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata_q;
    logic [15:0] temperature = 16'h0050; // healthy reading
    logic status_clear = 1'b0;
    logic clear_faults = 1'b0;
    logic output_cmd_on = 1'b1;
    logic bias_ok = 1'b1;
    int num_errors = 0;
    int checks_done = 0;
    // register rows: code, reset value, written, read back
    logic [7:0] rc [6] = '{8'h51, 8'h52, 8'h53, 8'h54, 8'hD2, 8'h60};
    logic [15:0] rs [5] = '{16'h7FFF, 16'h8000, 16'h8000, 16'h0000, 16'h0001};
    logic [15:0] rd [6] = '{16'h0100, 16'h0010, 16'h0000, 16'h12AB, 16'h0002, 16'h5555};
    logic [15:0] rx [6] = '{16'h0100, 16'h0010, 16'h0000, 16'h00AB, 16'h0002, 16'h0000};
    always #10 clk = ~clk;
    tfr_core tfr_core_inst (.clk, .nrst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .temperature,
        .status_clear, .clear_faults, .output_cmd_on, .bias_ok, .cmd_rdata_q, .cmd_ack_q, .output_en_q,
        .ut_fault_flag_q, .ot_warn_q, .ut_warn_q, .latched_off_q);
    tfr_host tfr_host_inst (.clk, .cmd_ack_q, .cmd_rdata_q, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata);
    // ====
    // shared tasks
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chk1(string what, logic seen, logic exp);
        check(what, {15'h0000, seen}, {15'h0000, exp});
    endtask
    task automatic acc(logic w, logic [7:0] c, logic [15:0] d, logic [15:0] exp);
        logic [15:0] r;
        logic ok;
        tfr_host_inst.xfer(w, c, d, r, ok);
        chk1("ack", ok, 1'b1);
        if (!w) check("rdata", r, exp);
    endtask
    task automatic look(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // heal, load the action byte, clear, then drop below the zero limit
    task automatic arm(logic [7:0] act);
        @(posedge clk) temperature <= 16'h0050;
        acc(1'b1, 8'h54, {8'h00, act}, 16'h0000);
        @(posedge clk) clear_faults <= 1'b1;
        @(posedge clk) clear_faults <= 1'b0;
        look(4);
        @(posedge clk) temperature <= 16'hFFF0;
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ====
    // cut a hang short
    initial begin
        #(20 * 6000);
        num_errors++;
        complete_run();
    end
    // ====
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        look(2);
        chk1("out_en", output_en_q, 1'b1);
        for (int i = 0; i < 5; i++) acc(1'b0, rc[i], 16'h0000, rs[i]);
        for (int i = 0; i < 6; i++) begin
            acc(1'b1, rc[i], rd[i], 16'h0000);
            acc(1'b0, rc[i], 16'h0000, rx[i]);
        end
        @(posedge clk) temperature <= 16'h0200;
        look(3);
        chk1("ot_warn", ot_warn_q, 1'b1);
        @(posedge clk) temperature <= 16'h0008;
        look(3);
        chk1("ut_warn", ut_warn_q, 1'b1);
        arm(8'h00);
        look(20);
        chk1("out_en", output_en_q, 1'b1);
        chk1("flag", ut_fault_flag_q, 1'b1);
        @(posedge clk) temperature <= 16'h0050;
        @(posedge clk) status_clear <= 1'b1;
        @(posedge clk) status_clear <= 1'b0;
        look(2);
        chk1("flag", ut_fault_flag_q, 1'b0);
        arm(8'hC0);
        look(4);
        @(posedge clk) temperature <= 16'h0050;
        look(20);
        chk1("latched", latched_off_q, 1'b1);
        @(posedge clk) clear_faults <= 1'b1;
        @(posedge clk) clear_faults <= 1'b0;
        look(4);
        chk1("out_en", output_en_q, 1'b1);
        arm(8'h80);
        look(20);
        chk1("latched", latched_off_q, 1'b1);
        @(posedge clk) bias_ok <= 1'b0;
        look(3);
        chk1("latched", latched_off_q, 1'b0);
        @(posedge clk) bias_ok <= 1'b1;
        // retry one to six times, four units of two cycles apart
        for (int n = 1; n < 7; n++) begin
            arm({2'b10, n[2:0], 3'b010});
            look(n * 8 - 1);
            chk1("early", latched_off_q, 1'b0);
            look(n * 2 + 5);
            chk1("latched", latched_off_q, 1'b1);
        end
        @(posedge clk) temperature <= 16'h0050;
        @(posedge clk) output_cmd_on <= 1'b0;
        @(posedge clk) output_cmd_on <= 1'b1;
        look(4);
        chk1("out_en", output_en_q, 1'b1);
        arm(8'hB8);
        look(150);
        chk1("latched", latched_off_q, 1'b0);
        chk1("out_en", output_en_q, 1'b0);
        @(posedge clk) temperature <= 16'h0050;
        look(20);
        chk1("out_en", output_en_q, 1'b1);
        arm(8'h43);
        look(12);
        chk1("out_en", output_en_q, 1'b1);
        look(26);
        chk1("latched", latched_off_q, 1'b1);
        complete_run();
    end
endmodule
